//--- hw/tw_pkg.sv
/*
 * Constants of the two-wire controller's status, interrupt and holding-register block:
 * register offsets, status bit positions, widths and reset values.
 * Assumes a 32-bit classic Wishbone register bus with word-aligned byte addresses.
 */
package tw_pkg;
    localparam int TW_ADR_W = 8;
    localparam int TW_CNT_W = 16;
    localparam int TW_SRC_W = 16;

    // Register byte offsets
    localparam logic [7:0] TW_OFS_STATUS = 8'h20;
    localparam logic [7:0] TW_OFS_IRQ_SET = 8'h24;
    localparam logic [7:0] TW_OFS_IRQ_CLR = 8'h28;
    localparam logic [7:0] TW_OFS_IRQ_STATE = 8'h2C;
    localparam logic [7:0] TW_OFS_RX_HOLD = 8'h30;
    localparam logic [7:0] TW_OFS_TX_HOLD = 8'h34;
    localparam logic [7:0] TW_OFS_FLAG_CLR = 8'h38;
    localparam logic [7:0] TW_OFS_RX_CNT = 8'h40;
    localparam logic [7:0] TW_OFS_RX_NEXT = 8'h44;
    localparam logic [7:0] TW_OFS_TX_CNT = 8'h48;
    localparam logic [7:0] TW_OFS_TX_NEXT = 8'h4C;

    // Status bit positions
    localparam int TW_B_COMPLETE = 0;
    localparam int TW_B_RX_FULL = 1;
    localparam int TW_B_TX_FREE = 2;
    localparam int TW_B_SLV_READ = 3;
    localparam int TW_B_ADDRESSED = 4;
    localparam int TW_B_GCALL = 5;
    localparam int TW_B_OVERRUN = 6;
    localparam int TW_B_NACK = 8;
    localparam int TW_B_ARB_LOST = 9;
    localparam int TW_B_STRETCH = 10;
    localparam int TW_B_ACC_DONE = 11;
    localparam int TW_B_RX_DONE = 12;
    localparam int TW_B_TX_DONE = 13;
    localparam int TW_B_RX_CHAIN = 14;
    localparam int TW_B_TX_CHAIN = 15;

    // Fourteen maskable sources: bits 3 and 7 are not sources
    localparam logic [15:0] TW_SRC_VALID = 16'hFF77;
    localparam logic [15:0] TW_MASK_RESET = 16'h0000;
    localparam logic [7:0] TW_TX_HOLD_RESET = 8'h00;
    localparam logic [7:0] TW_RX_HOLD_RESET = 8'h00;
    localparam logic [15:0] TW_CNT_RESET = 16'h0000;
    localparam logic [31:0] TW_READ_ZERO = 32'h0000_0000;
endpackage

//--- hw/tw_count_pair.sv
/*
 * One chained transfer counter pair (current and next) with its done and chain flags.
 * Assumes the writer and the transfer strobe are on clk_sys; writes and strobes are pulses.
 */
`timescale 1ns/1ns
module tw_count_pair
    import tw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wr_cur,
    input wire logic wr_next,
    input wire logic [TW_CNT_W-1:0] wr_data,
    input wire logic step,
    output logic [TW_CNT_W-1:0] cur,
    output logic [TW_CNT_W-1:0] nxt,
    output logic done,
    output logic chain_zero
);
    logic [TW_CNT_W-1:0] next_cur;
    logic [TW_CNT_W-1:0] next_nxt;
    logic next_done;
    wire cur_zero = (cur == TW_CNT_RESET);
    wire nxt_zero = (nxt == TW_CNT_RESET);
    wire hit_zero = step && (cur == TW_CNT_W'(1));

    // Reaching zero reloads from next, so the chain runs on without software
    assign next_cur = wr_cur ? wr_data :
                      (hit_zero && !nxt_zero) ? nxt :
                      (step && !cur_zero) ? cur - TW_CNT_W'(1) : cur;
    assign next_nxt = wr_next ? wr_data : (hit_zero ? TW_CNT_RESET : nxt);
    // Any counter write restarts the done flag; a zero hit in the same cycle still wins
    assign next_done = hit_zero ? 1'b1 : ((wr_cur || wr_next) ? 1'b0 : done);
    assign chain_zero = cur_zero && nxt_zero;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cur <= TW_CNT_RESET;
            nxt <= TW_CNT_RESET;
            done <= 1'b0;
        end else begin
            cur <= next_cur;
            nxt <= next_nxt;
            done <= next_done;
        end
    end
endmodule

//--- hw/tw_irq_hold.sv
/*
 * Status, interrupt mask and data holding registers of a two-wire serial controller,
 * reached over classic Wishbone. The protocol engine, shifter and address decoder sit
 * outside and talk to this block through plain same-clock strobes and levels; only the
 * bus pins are sampled here, to catch a stop condition.
 */
// Notes on behaviour
// - In slave mode the access-done flag sets when the addressed flag falls, reads 0 during an access.
// - The access-done flag is cleared by reading the status register and matters only in slave mode.
// - In master mode the receive-done flag is high once the receive counter reached zero since its last write.
// - In master mode the transmit-done flag is high once the transmit counter reached zero since its last write.
// - In master mode receive-chain-full is 1 only when both receive counters are zero.
// - In master mode transmit-chain-empty is 1 only when both transmit counters are zero.
// - Writing the enable-set register sets each mask bit written 1 and leaves the others alone.
// - Writing the enable-clear register clears each mask bit written 1 and leaves the others alone.
// - The enable-state register reads 1 for enabled sources, and all are disabled after reset.
// - The mask covers fourteen sources at the status positions, bits 3 and 7 excluded.
// - The receive holding register shows the last received byte in bits 7 to 0, upper bits zero.
// - The transmit holding register takes the next byte in bits 7 to 0 and resets to zero.
// - The addressed flag sets on an address match and holds until a NACK or stop is seen.
`timescale 1ns/1ns
module tw_irq_hold
    import tw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [TW_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic master_mode,
    input wire logic slave_mode,
    input wire logic address_match,
    input wire logic nack_seen,
    input wire logic slave_read_direction,
    input wire logic transfer_complete,
    input wire logic tx_holding_free,
    input wire logic general_call_seen,
    input wire logic receive_overrun,
    input wire logic arbitration_lost,
    input wire logic clock_stretch_wait,
    input wire logic rx_byte_valid,
    input wire logic [7:0] received_byte,
    input wire logic rx_step,
    input wire logic tx_step,
    output logic [7:0] byte_to_send,
    output logic tx_holding_written,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic ack;
    logic [31:0] rdata;
    wire req = wb_cyc_i && wb_stb_i && !ack;
    wire wr = req && wb_we_i;
    wire rd = req && !wb_we_i;
    wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wdata = wb_dat_i & wmask;
    wire sel_status = (wb_adr_i == TW_OFS_STATUS);
    wire sel_irq_set = (wb_adr_i == TW_OFS_IRQ_SET);
    wire sel_irq_clr = (wb_adr_i == TW_OFS_IRQ_CLR);
    wire sel_irq_state = (wb_adr_i == TW_OFS_IRQ_STATE);
    wire sel_rx_hold = (wb_adr_i == TW_OFS_RX_HOLD);
    wire sel_tx_hold = (wb_adr_i == TW_OFS_TX_HOLD);
    wire sel_flag_clr = (wb_adr_i == TW_OFS_FLAG_CLR);
    wire sel_rx_cnt = (wb_adr_i == TW_OFS_RX_CNT);
    wire sel_rx_next = (wb_adr_i == TW_OFS_RX_NEXT);
    wire sel_tx_cnt = (wb_adr_i == TW_OFS_TX_CNT);
    wire sel_tx_next = (wb_adr_i == TW_OFS_TX_NEXT);
    wire status_read = rd && sel_status;
    wire rx_hold_read = rd && sel_rx_hold;
    wire tx_hold_write = wr && sel_tx_hold && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling and stop detection
    logic scl_meta;
    logic scl_sync;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= scl_pin;
            scl_sync <= scl_meta;
            sda_meta <= sda_pin;
            sda_sync <= sda_meta;
            sda_prev <= sda_sync;
        end
    end
    // Stop: data rises while the clock is high
    wire stop_seen = scl_sync && sda_sync && !sda_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Slave access tracking
    logic slave_addressed;
    logic slave_access_done;
    wire next_addressed = address_match ? 1'b1 :
                          (nack_seen || stop_seen) ? 1'b0 : slave_addressed;
    wire access_end = slave_mode && slave_addressed && !next_addressed;
    // Set wins over the read clear so an end landing on a status read is kept
    wire next_access_done = access_end ? 1'b1 :
                            (status_read || (wr && sel_flag_clr && wdata[TW_B_ACC_DONE]) ||
                             address_match) ? 1'b0 : slave_access_done;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            slave_addressed <= 1'b0;
            slave_access_done <= 1'b0;
        end else begin
            slave_addressed <= next_addressed;
            slave_access_done <= next_access_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer counters
    logic [TW_CNT_W-1:0] rx_transfer_counter;
    logic [TW_CNT_W-1:0] rx_next_counter;
    logic [TW_CNT_W-1:0] tx_transfer_counter;
    logic [TW_CNT_W-1:0] tx_next_counter;
    logic rx_done_raw;
    logic tx_done_raw;
    logic rx_zero;
    logic tx_zero;
    tw_count_pair u_rx_count (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_cur(wr && sel_rx_cnt),
        .wr_next(wr && sel_rx_next),
        .wr_data(wdata[TW_CNT_W-1:0]),
        .step(rx_step),
        .cur(rx_transfer_counter),
        .nxt(rx_next_counter),
        .done(rx_done_raw),
        .chain_zero(rx_zero)
    );
    tw_count_pair u_tx_count (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_cur(wr && sel_tx_cnt),
        .wr_next(wr && sel_tx_next),
        .wr_data(wdata[TW_CNT_W-1:0]),
        .step(tx_step),
        .cur(tx_transfer_counter),
        .nxt(tx_next_counter),
        .done(tx_done_raw),
        .chain_zero(tx_zero)
    );
    // Buffer flags only mean something to a master; a slave sees them low
    wire rx_count_done = master_mode && rx_done_raw;
    wire tx_count_done = master_mode && tx_done_raw;
    wire rx_chain_full = master_mode && rx_zero;
    wire tx_chain_empty = master_mode && tx_zero;

    ////////////////////////////////////////////////////////////////////////////
    // Holding registers
    logic [7:0] rx_hold;
    logic rx_holding_full;
    wire next_rx_full = rx_byte_valid ? 1'b1 : (rx_hold_read ? 1'b0 : rx_holding_full);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_hold <= TW_RX_HOLD_RESET;
            rx_holding_full <= 1'b0;
            byte_to_send <= TW_TX_HOLD_RESET;
            tx_holding_written <= 1'b0;
        end else begin
            if (rx_byte_valid) begin
                rx_hold <= received_byte;
            end
            rx_holding_full <= next_rx_full;
            if (tx_hold_write) begin
                byte_to_send <= wdata[7:0];
            end
            tx_holding_written <= tx_hold_write;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status, mask and interrupt
    logic [TW_SRC_W-1:0] irq_enable_state;
    wire [TW_SRC_W-1:0] status = {
        tx_chain_empty, rx_chain_full, tx_count_done, rx_count_done,
        slave_access_done, clock_stretch_wait, arbitration_lost, nack_seen,
        1'b0, receive_overrun, general_call_seen, slave_addressed,
        slave_read_direction, tx_holding_free, rx_holding_full, transfer_complete
    };
    wire [TW_SRC_W-1:0] mask_set = (wr && sel_irq_set) ? wdata[TW_SRC_W-1:0] : TW_MASK_RESET;
    wire [TW_SRC_W-1:0] mask_clr = (wr && sel_irq_clr) ? wdata[TW_SRC_W-1:0] : TW_MASK_RESET;
    wire [TW_SRC_W-1:0] next_mask = ((irq_enable_state | mask_set) & ~mask_clr)
                                    & TW_SRC_VALID;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_enable_state <= TW_MASK_RESET;
            irq <= 1'b0;
        end else begin
            irq_enable_state <= next_mask;
            irq <= |(status & irq_enable_state);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge
    // Every address answers; unmapped and write-only ones read zero
    wire [31:0] next_rdata =
        sel_status ? {16'h0000, status} :
        sel_irq_state ? {16'h0000, irq_enable_state} :
        sel_rx_hold ? {24'h000000, rx_hold} :
        sel_tx_hold ? {24'h000000, byte_to_send} :
        sel_rx_cnt ? {16'h0000, rx_transfer_counter} :
        sel_rx_next ? {16'h0000, rx_next_counter} :
        sel_tx_cnt ? {16'h0000, tx_transfer_counter} :
        sel_tx_next ? {16'h0000, tx_next_counter} : TW_READ_ZERO;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack <= 1'b0;
            rdata <= TW_READ_ZERO;
        end else begin
            ack <= req;
            if (rd) begin
                rdata <= next_rdata;
            end
        end
    end
    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
endmodule

//--- sim/tw_bus_model.sv
/*
 * Far side of the two-wire bus: another master that sends one byte and a stop.
 * Assumes pull-ups on both lines, so idle lines read high.
 */
`timescale 1ns/1ns
module tw_bus_model (
    output logic scl,
    output logic sda
);
    // The clock stands high between frames and toggles at 80 ns only inside one
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic frame(input logic [7:0] b);
        // Keep every pin change off the system clock edges
        #1;
        sda = 1'b0;
        #40;
        for (int i = 7; i >= 0; i--) begin
            scl = 1'b0;
            #20 sda = b[i];
            #20 scl = 1'b1;
            #40;
        end
        scl = 1'b0;
        #20 sda = 1'b0;
        #20 scl = 1'b1;
        #40 sda = 1'b1;
    endtask
endmodule

//--- sim/tw_irq_hold_assertions.sv
/*
 * Port checker of tw_irq_hold.
 * Assumes it is bound to the block and sees only its ports.
 */
`timescale 1ns/1ns
module tw_irq_hold_check
    import tw_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [TW_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic master_mode,
    input wire logic rx_byte_valid,
    input wire logic [7:0] received_byte,
    input wire logic [7:0] byte_to_send,
    input wire logic irq
);
    logic [15:0] msk;
    logic [7:0] rxb;
    wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = tk && wb_we_i;
    wire rd = wb_ack_o && !wb_we_i;
    wire rd_st = rd && wb_adr_i == TW_OFS_IRQ_STATE;
    wire rd_sr = rd && wb_adr_i == TW_OFS_STATUS;
    wire rd_rx = rd && wb_adr_i == TW_OFS_RX_HOLD;
    wire [15:0] wd = wb_dat_i[15:0] & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    // Mask shadow built from bus traffic alone, so it cannot share a slip with the block
    wire [15:0] next_msk = (wr && wb_adr_i == TW_OFS_IRQ_SET) ? ((msk | wd) & TW_SRC_VALID)
        : (wr && wb_adr_i == TW_OFS_IRQ_CLR) ? (msk & ~wd) : msk;
    always_ff @(posedge clk_sys) begin
        msk <= reset ? TW_MASK_RESET : next_msk;
        rxb <= reset ? TW_RX_HOLD_RESET : (rx_byte_valid ? received_byte : rxb);
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (tk |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_state_read: assert property (rd_st |-> wb_dat_o == {16'h0000, msk})
        else $error("enable state differs from set and clear history");
    a_irq_needs_mask: assert property (irq |-> $past(msk) != 16'h0000)
        else $error("irq high with every source disabled");
    a_irq_after_reset: assert property ($fell(reset) |-> !irq)
        else $error("irq high straight after reset");
    a_rx_hold_read: assert property (rd_rx |-> wb_dat_o == {24'h000000, rxb})
        else $error("receive holding read wrong");
    a_tx_hold_load: assert property (wr && wb_adr_i == TW_OFS_TX_HOLD && wb_sel_i[0]
        |=> byte_to_send == $past(wb_dat_i[7:0]))
        else $error("transmit holding not loaded");
    a_chain_slave: assert property (rd_sr && !master_mode |-> wb_dat_o[15:14] == 2'b00)
        else $error("chain flags set outside master mode");
    c_irq_rise: cover property ($rose(irq));
    c_state_read: cover property (rd_st);
    c_status_master: cover property (rd_sr && master_mode);
endmodule

bind tw_irq_hold tw_irq_hold_check i_tw_irq_hold_check (.clk_sys(clk_sys), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .master_mode(master_mode), .rx_byte_valid(rx_byte_valid), .received_byte(received_byte),
    .byte_to_send(byte_to_send), .irq(irq));

//--- sim/tw_irq_hold_test.sv
/*
 * Self-checking bench of tw_irq_hold: Wishbone tasks and one task per scenario.
 * Assumes the checker is bound in and the bus model drives the two-wire pins.
 */
`timescale 1ns/1ns
module tw_irq_hold_test;
    import tw_pkg::*;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
    int n_errors = 0;
    int checks = 0;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, mm = 1'b0, sm = 1'b0, nack = 1'b0;
    logic [7:0] adr = 8'h00, rbyte = 8'h00;
    logic [3:0] sel = 4'h0, pl = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, q;
    logic [6:0] lv = 7'h00;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, scl, sda, irq, thw;
    wire [7:0] bts;
    localparam int POS[7] = '{TW_B_SLV_READ, TW_B_COMPLETE, TW_B_TX_FREE, TW_B_GCALL,
        TW_B_OVERRUN, TW_B_ARB_LOST, TW_B_STRETCH};
    always #4 clk_sys = ~clk_sys;
    tw_bus_model i_tw_bus_model (.scl(scl), .sda(sda));
    tw_irq_hold i_tw_irq_hold (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .scl_pin(scl), .sda_pin(sda), .master_mode(mm), .slave_mode(sm),
        .address_match(pl[0]), .nack_seen(nack), .slave_read_direction(lv[0]),
        .transfer_complete(lv[1]), .tx_holding_free(lv[2]), .general_call_seen(lv[3]),
        .receive_overrun(lv[4]), .arbitration_lost(lv[5]), .clock_stretch_wait(lv[6]),
        .rx_byte_valid(pl[1]), .received_byte(rbyte), .rx_step(pl[2]), .tx_step(pl[3]),
        .byte_to_send(bts), .tx_holding_written(thw), .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        // Only the watchdog ends a wait that never sees an acknowledge
        do begin
            @(posedge clk_sys);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, q)
    endtask
    // Strobes last one cycle, then the block gets two idle cycles to settle its flags
    task automatic pulse(input int i);
        @(posedge clk_sys) pl[i] <= 1'b1;
        @(posedge clk_sys) pl <= 4'h0;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        rd_chk(TW_OFS_IRQ_STATE, 32'h0, "enable state");
        rd_chk(TW_OFS_TX_HOLD, 32'h0, "tx holding");
        rd_chk(TW_OFS_RX_HOLD, 32'h0, "rx holding");
        rd_chk(8'h7C, 32'h0, "unmapped");
        `CHK("irq", 1'b0, irq)
    endtask
    task automatic t_levels();
        for (int i = 0; i < 7; i++) begin
            @(posedge clk_sys) lv <= 7'h01 << i;
            rd_chk(TW_OFS_STATUS, 32'h1 << POS[i], "status level");
        end
        @(posedge clk_sys) lv <= 7'h00;
    endtask
    task automatic t_mask();
        wb(1'b1, TW_OFS_IRQ_SET, 32'hFFFF_FFFF);
        rd_chk(TW_OFS_IRQ_STATE, 32'h0000_FF77, "all set");
        wb(1'b1, TW_OFS_IRQ_CLR, 32'h0000_0004);
        rd_chk(TW_OFS_IRQ_STATE, 32'h0000_FF73, "one cleared");
        wb(1'b1, TW_OFS_IRQ_SET, 32'h0000_0008);
        rd_chk(TW_OFS_IRQ_STATE, 32'h0000_FF73, "bit 3 set");
        wb(1'b1, TW_OFS_IRQ_CLR, 32'hFFFF_FFFF);
        rd_chk(TW_OFS_IRQ_STATE, 32'h0, "all cleared");
    endtask
    task automatic t_irq();
        @(posedge clk_sys) lv <= 7'h04;
        wb(1'b1, TW_OFS_IRQ_SET, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        `CHK("irq masked", 1'b0, irq)
        wb(1'b1, TW_OFS_IRQ_SET, 32'h0000_0004);
        repeat (3) @(posedge clk_sys);
        `CHK("irq enabled", 1'b1, irq)
        wb(1'b1, TW_OFS_IRQ_CLR, 32'h0000_FFFF);
        repeat (3) @(posedge clk_sys);
        `CHK("irq cleared", 1'b0, irq)
        @(posedge clk_sys) lv <= 7'h00;
    endtask
    task automatic t_hold();
        @(posedge clk_sys) rbyte <= 8'hA5;
        pulse(1);
        rd_chk(TW_OFS_RX_HOLD, 32'h0000_00A5, "rx byte");
        wb(1'b1, TW_OFS_TX_HOLD, 32'hFFFF_FF3C);
        `CHK("tx written", 1'b1, thw)
        @(posedge clk_sys);
        `CHK("byte out", 8'h3C, bts)
        `CHK("tx written gone", 1'b0, thw)
        rd_chk(TW_OFS_TX_HOLD, 32'h0000_003C, "tx byte");
    endtask
    task automatic t_slave();
        @(posedge clk_sys) sm <= 1'b1;
        pulse(0);
        rd_chk(TW_OFS_STATUS, 32'h0000_0010, "in access");
        i_tw_bus_model.frame(8'h5A);
        repeat (5) @(posedge clk_sys);
        rd_chk(TW_OFS_STATUS, 32'h0000_0800, "access done");
        rd_chk(TW_OFS_STATUS, 32'h0, "done read");
        pulse(0);
        @(posedge clk_sys) nack <= 1'b1;
        rd_chk(TW_OFS_STATUS, 32'h0000_0900, "nack ends access");
        @(posedge clk_sys) nack <= 1'b0;
        rd_chk(TW_OFS_STATUS, 32'h0, "nack done read");
        @(posedge clk_sys) sm <= 1'b0;
    endtask
    task automatic t_count();
        @(posedge clk_sys) mm <= 1'b1;
        rd_chk(TW_OFS_STATUS, 32'h0000_C000, "chains idle");
        wb(1'b1, TW_OFS_RX_CNT, 32'h1);
        rd_chk(TW_OFS_STATUS, 32'h0000_8000, "rx loaded");
        pulse(2);
        rd_chk(TW_OFS_STATUS, 32'h0000_D000, "rx run out");
        wb(1'b1, TW_OFS_RX_NEXT, 32'h0);
        rd_chk(TW_OFS_STATUS, 32'h0000_C000, "rx rewritten");
        wb(1'b1, TW_OFS_TX_CNT, 32'h1);
        wb(1'b1, TW_OFS_TX_NEXT, 32'h1);
        rd_chk(TW_OFS_STATUS, 32'h0000_4000, "tx loaded");
        pulse(3);
        rd_chk(TW_OFS_STATUS, 32'h0000_6000, "tx reload");
        pulse(3);
        rd_chk(TW_OFS_STATUS, 32'h0000_E000, "tx run out");
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_levels();
        t_mask();
        t_irq();
        t_hold();
        t_slave();
        t_count();
        close_out();
    end
    initial begin
        #400000;
        n_errors++;
        close_out();
    end
endmodule
